/* File: rtl/mefe_top.sv */
/*
  Meter event flags and interrupt enables: sticky event status for high
  voltage, phase order, neutral sum disagreement and peak period ends,
  energy half events and line-cycle done, with masks and one interrupt.
  Assumes all event inputs come from the metering DSP on core_clk_i,
  and a register master that follows the plain strobe protocol.
*/
// How it works
// - High voltage on any phase sets status bit 18; phase field bits 11:9.
// - Phase A rising crossing followed by C instead of B sets bit 19.
// - Bit 20 set when absolute difference of sum and neutral magnitudes exceeds threshold.
// - Reserved status bit 21 always reads one.
// - Reserved status bit 22 always reads zero.
// - Current peak period end sets bit 23; current peak register holds result.
// - Voltage peak period end sets bit 24; voltage peak register holds result.
// - Status bits 31 to 25 always read zero.
// - Enable bit 0 interrupts on bit 30 change of total real energies.
// - Enable bit 1 interrupts on bit 30 change of fundamental real energies.
// - Enable bit 2 interrupts on bit 30 change of total quadrature energies.
// - Enable bit 3 interrupts on bit 30 change of fundamental quadrature energies.
// - Enable bit 4 interrupts on bit 30 change of apparent energies.
// - Enable bit 5 interrupts when line-cycle mode finishes its half-cycle count.
`timescale 1ns/1ps
module mefe_top (
  input  wire logic                         core_clk_i,
  input  wire logic                         sys_rst_i,
  // Register port
  input  wire logic [mefe_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [mefe_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [mefe_pkg::DATA_W-1:0]  reg_rdata_o,
  // High voltage detector
  input  wire logic                         high_voltage_i,
  input  wire logic [2:0]                   high_voltage_phase_i,
  // Rising zero crossings of phase voltages
  input  wire logic                         zx_rise_a_i,
  input  wire logic                         zx_rise_b_i,
  input  wire logic                         zx_rise_c_i,
  // Neutral current comparison
  input  wire logic                         sample_valid_i,
  input  wire logic signed [27:0]           computed_current_total_i,
  input  wire logic signed [27:0]           neutral_current_sample_i,
  // Peak detectors
  input  wire logic                         current_peak_end_i,
  input  wire logic [31:0]                  current_peak_value_i,
  input  wire logic                         voltage_peak_end_i,
  input  wire logic [31:0]                  voltage_peak_value_i,
  // Bit 30 of each phase accumulator, phase A in bit 0
  input  wire logic [2:0]                   real_energy_b30_i,
  input  wire logic [2:0]                   fund_real_energy_b30_i,
  input  wire logic [2:0]                   quad_energy_b30_i,
  input  wire logic [2:0]                   fund_quad_energy_b30_i,
  input  wire logic [2:0]                   apparent_energy_b30_i,
  // One pulse per line half cycle
  input  wire logic                         half_cycle_tick_i,
  output logic                              irq_o
);
  import mefe_pkg::*;

  // Software visible storage
  logic [4:0]           upper_status_reg;
  logic [4:0]           upper_status_next;
  logic [5:0]           energy_status_reg;
  logic [5:0]           energy_status_next;
  logic [5:0]           enable_first_reg;
  logic [4:0]           enable_upper_reg;
  logic [THRESH_W-1:0]  thresh_reg;
  logic [2:0]           hv_phase_reg;
  logic [2:0]           hv_phase_next;
  logic [HALFCYC_W-1:0] halfcyc_reg;
  logic                 line_mode_reg;
  logic [31:0]          cur_peak_reg;
  logic [31:0]          volt_peak_reg;
  logic [HALFCYC_W-1:0] cycle_cnt_reg;
  logic [HALFCYC_W-1:0] cycle_cnt_next;
  logic                 mismatch_reg;

  // Decoded accesses
  logic        wr_status;
  logic        wr_energy;
  logic        wr_en_first;
  logic        wr_en_upper;
  logic        wr_thresh;
  logic        wr_halfcyc;
  logic        wr_line;
  logic [31:0] rd_mux;
  logic [31:0] status_view;
  logic [31:0] energy_view;
  logic [31:0] phase_view;
  logic [31:0] enable_upper_view;

  // Event sources
  logic                    order_err;
  logic [ENERGY_KINDS-1:0] energy_half;
  logic [14:0]             energy_b30_all;
  logic                    line_done;
  logic [4:0]              upper_set;
  logic [5:0]              energy_set;
  logic [4:0]              upper_clr;
  logic [5:0]              energy_clr;

  // Neutral comparison datapath
  logic [27:0] sum_mag;
  logic [27:0] neut_mag;
  logic [27:0] mag_diff;
  logic        mismatch_now;

  // Magnitude of a signed 28-bit sample
  // The most negative value still fits unsigned
  function automatic logic [27:0] mag28(input logic signed [27:0] v);
    mag28 = v[27] ? 28'(-v) : 28'(v);
  endfunction

  // Write strobe qualified by one address
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = reg_wr_i & (reg_addr_i == a);
  endfunction

  // Address decode for writes
  assign wr_status   = hit(ADDR_EVENT_STATUS_FIRST);
  assign wr_energy   = hit(ADDR_ENERGY_STATUS);
  assign wr_en_first = hit(ADDR_INTERRUPT_EN_FIRST);
  assign wr_en_upper = hit(ADDR_EVENT_ENABLE_UPPER);
  assign wr_thresh   = hit(ADDR_SUM_DISAGREE_THRESH);
  assign wr_halfcyc  = hit(ADDR_HALF_CYCLE_COUNT);
  assign wr_line     = hit(ADDR_LINE_CONTROL);

  // Phase order checker
  // Crossings come from the DSP clock, no sync
  mefe_seq_check u_seq (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .zx_a_i      (zx_rise_a_i),
    .zx_b_i      (zx_rise_b_i),
    .zx_c_i      (zx_rise_c_i),
    .order_err_o (order_err)
  );

  // Accumulator groups in enable bit order
  assign energy_b30_all = {apparent_energy_b30_i,
                           fund_quad_energy_b30_i,
                           quad_energy_b30_i,
                           fund_real_energy_b30_i,
                           real_energy_b30_i};

  // One watcher per energy kind
  genvar g;
  generate
    for (g = 0; g < ENERGY_KINDS; g++)
    begin : g_watch
      mefe_bit30_watch #(
        .N (3)
      ) u_watch (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .bit30_i    (energy_b30_all[3*g +: 3]),
        .change_o   (energy_half[g])
      );
    end
  endgenerate

  // Absolute difference of magnitudes against zero-extended threshold
  assign sum_mag      = mag28(computed_current_total_i);
  assign neut_mag     = mag28(neutral_current_sample_i);
  assign mag_diff     = (sum_mag >= neut_mag) ? (sum_mag - neut_mag)
                                              : (neut_mag - sum_mag);
  assign mismatch_now = sample_valid_i
                        & (mag_diff > {4'h0, thresh_reg});

  // Line-cycle counter: a zero count never finishes, so no event storm
  // A count write restarts the period
  assign line_done = line_mode_reg & half_cycle_tick_i
                     & (halfcyc_reg != RST_HALFCYC)
                     & (cycle_cnt_reg == halfcyc_reg - 16'h0001);

  always_comb
  begin
    cycle_cnt_next = cycle_cnt_reg;
    if (!line_mode_reg || wr_halfcyc)
      cycle_cnt_next = RST_HALFCYC;
    else if (line_done)
      cycle_cnt_next = RST_HALFCYC;
    else if (half_cycle_tick_i)
      cycle_cnt_next = cycle_cnt_reg + 16'h0001;
  end

  // Set vectors, ordered as stored: 24,23,20,19,18
  // Sum disagree arrives one cycle late, from its stage
  assign upper_set = {voltage_peak_end_i,
                      current_peak_end_i,
                      mismatch_reg,
                      order_err,
                      high_voltage_i};

  // Energy events in enable bit order
  assign energy_set = {line_done, energy_half};

  // Write-one-to-clear masks taken from matching data bits
  assign upper_clr  = wr_status ? {reg_wdata_i[BIT_VOLTAGE_PEAK],
                                   reg_wdata_i[BIT_CURRENT_PEAK],
                                   reg_wdata_i[BIT_SUM_DISAGREE],
                                   reg_wdata_i[BIT_PHASE_ORDER],
                                   reg_wdata_i[BIT_HIGH_VOLTAGE]}
                                : 5'h0_0;
  assign energy_clr = wr_energy ? reg_wdata_i[ENERGY_EVT_W-1:0] : 6'h0_0;

  // A set in the same cycle as its clear wins
  assign upper_status_next  = (upper_status_reg & ~upper_clr) | upper_set;
  assign energy_status_next = (energy_status_reg & ~energy_clr)
                              | energy_set;

  // Phase field gathers phases; cleared with the high voltage flag
  assign hv_phase_next = ((upper_clr[0] ? 3'h0 : hv_phase_reg))
                         | (high_voltage_i ? high_voltage_phase_i : 3'h0);

  // Status as read: reserved bits fixed, lower bits belong elsewhere
  assign status_view = {7'h00,
                        upper_status_reg[4],
                        upper_status_reg[3],
                        1'b0,
                        1'b1,
                        upper_status_reg[2],
                        upper_status_reg[1],
                        upper_status_reg[0],
                        18'h0_0000};

  assign energy_view = {26'h000_0000, energy_status_reg};
  assign phase_view  = {20'h0_0000, hv_phase_reg, 9'h000};

  // Upper enables shown at the status bits they gate
  assign enable_upper_view = {7'h00, enable_upper_reg[4:3], 2'h0,
                              enable_upper_reg[2:0], 18'h0_0000};

  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    case (reg_addr_i)
      ADDR_EVENT_STATUS_FIRST:  rd_mux = status_view;
      ADDR_ENERGY_STATUS:       rd_mux = energy_view;
      ADDR_INTERRUPT_EN_FIRST:  rd_mux = {26'h000_0000, enable_first_reg};
      ADDR_EVENT_ENABLE_UPPER:  rd_mux = enable_upper_view;
      ADDR_SUM_DISAGREE_THRESH: rd_mux = {8'h00, thresh_reg};
      ADDR_PHASE_EVENT:         rd_mux = phase_view;
      ADDR_HALF_CYCLE_COUNT:    rd_mux = {16'h0000, halfcyc_reg};
      ADDR_LINE_CONTROL:        rd_mux = {31'h0000_0000, line_mode_reg};
      ADDR_CURRENT_PEAK:        rd_mux = cur_peak_reg;
      ADDR_VOLTAGE_PEAK:        rd_mux = volt_peak_reg;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // Status, phase field and comparison stage
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      upper_status_reg  <= RST_STATUS_FIRST[4:0];
      energy_status_reg <= RST_STATUS_FIRST[5:0];
      hv_phase_reg      <= 3'h0;
      mismatch_reg      <= 1'b0;
      cycle_cnt_reg     <= RST_HALFCYC;
    end
    else
    begin
      upper_status_reg  <= upper_status_next;
      energy_status_reg <= energy_status_next;
      hv_phase_reg      <= hv_phase_next;
      mismatch_reg      <= mismatch_now;
      cycle_cnt_reg     <= cycle_cnt_next;
    end
  end

  // Enables and configuration
  // Unused data bits of each write are dropped
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      enable_first_reg <= RST_ENABLE[5:0];
      enable_upper_reg <= RST_ENABLE[4:0];
      thresh_reg       <= RST_THRESH;
      halfcyc_reg      <= RST_HALFCYC;
      line_mode_reg    <= 1'b0;
    end
    else
    begin
      if (wr_en_first)
        enable_first_reg <= reg_wdata_i[ENERGY_EVT_W-1:0];
      if (wr_en_upper)
        enable_upper_reg <= {reg_wdata_i[BIT_VOLTAGE_PEAK],
                             reg_wdata_i[BIT_CURRENT_PEAK],
                             reg_wdata_i[BIT_SUM_DISAGREE],
                             reg_wdata_i[BIT_PHASE_ORDER],
                             reg_wdata_i[BIT_HIGH_VOLTAGE]};
      if (wr_thresh)
        thresh_reg <= reg_wdata_i[THRESH_W-1:0];
      if (wr_halfcyc)
        halfcyc_reg <= reg_wdata_i[HALFCYC_W-1:0];
      if (wr_line)
        line_mode_reg <= reg_wdata_i[BIT_LINE_MODE];
    end
  end

  // Peak results latched at the end of each detection period
  // An unread result is overwritten by the next
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cur_peak_reg  <= RST_PEAK;
      volt_peak_reg <= RST_PEAK;
    end
    else
    begin
      if (current_peak_end_i)
        cur_peak_reg <= current_peak_value_i;
      if (voltage_peak_end_i)
        volt_peak_reg <= voltage_peak_value_i;
    end
  end

  // Read data stands only in the cycle after the strobe
  // Zero otherwise, so stale data never lingers
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= 32'h0000_0000;
  end

  // Level interrupt; status sets regardless of the enables
  // Drops right after the clearing write
  assign irq_o = (|(energy_status_reg & enable_first_reg))
                 | (|(upper_status_reg & enable_upper_reg));

endmodule

/* File: rtl/mefe_pkg.sv */
/*
  Shared constants of the meter event flag and interrupt enable block:
  register addresses, field positions, reset values and widths.
  Assumes a 16-bit word address on the register port, 32-bit data.
*/
package mefe_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // Register word addresses
  localparam logic [15:0] ADDR_EVENT_STATUS_FIRST  = 16'hE500;
  localparam logic [15:0] ADDR_ENERGY_STATUS       = 16'hE501;
  localparam logic [15:0] ADDR_INTERRUPT_EN_FIRST  = 16'hE50A;
  localparam logic [15:0] ADDR_EVENT_ENABLE_UPPER  = 16'hE50C;
  localparam logic [15:0] ADDR_SUM_DISAGREE_THRESH = 16'hE510;
  localparam logic [15:0] ADDR_PHASE_EVENT         = 16'hE511;
  localparam logic [15:0] ADDR_HALF_CYCLE_COUNT    = 16'hE512;
  localparam logic [15:0] ADDR_LINE_CONTROL        = 16'hE513;
  localparam logic [15:0] ADDR_CURRENT_PEAK        = 16'hE514;
  localparam logic [15:0] ADDR_VOLTAGE_PEAK        = 16'hE515;

  // Event status, upper part
  localparam int unsigned BIT_HIGH_VOLTAGE   = 18;
  localparam int unsigned BIT_PHASE_ORDER    = 19;
  localparam int unsigned BIT_RSVD_ONE       = 21;
  localparam int unsigned BIT_RSVD_ZERO      = 22;
  localparam int unsigned BIT_SUM_DISAGREE   = 20;
  localparam int unsigned BIT_CURRENT_PEAK   = 23;
  localparam int unsigned BIT_VOLTAGE_PEAK   = 24;

  // Interrupt enable first: energy half bits and line cycle done
  localparam int unsigned BIT_TOTAL_REAL_HALF = 0;
  localparam int unsigned BIT_FUND_REAL_HALF  = 1;
  localparam int unsigned BIT_TOTAL_QUAD_HALF = 2;
  localparam int unsigned BIT_FUND_QUAD_HALF  = 3;
  localparam int unsigned BIT_APPARENT_HALF   = 4;
  localparam int unsigned BIT_LINE_CYCLE_DONE = 5;
  localparam int unsigned ENERGY_KINDS        = 5;
  localparam int unsigned ENERGY_EVT_W        = 6;

  // Phase event register: high voltage phase field
  localparam int unsigned HV_PHASE_LSB = 9;
  localparam int unsigned HV_PHASE_MSB = 11;

  // Line control bit: line-cycle accumulation mode
  localparam int unsigned BIT_LINE_MODE = 0;

  // Field widths
  localparam int unsigned THRESH_W   = 24;
  localparam int unsigned HALFCYC_W  = 16;

  // Reset values
  localparam logic [31:0] RST_STATUS_FIRST = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLE       = 32'h0000_0000;
  localparam logic [23:0] RST_THRESH       = 24'h00_0000;
  localparam logic [15:0] RST_HALFCYC      = 16'h0000;
  localparam logic [31:0] RST_PEAK         = 32'h0000_0000;

  // Phase order checker states
  typedef enum logic [0:0] {
    MEFE_WAIT_A  = 1'b0,
    MEFE_AFTER_A = 1'b1
  } mefe_seq_state_t;

endpackage

/* File: rtl/mefe_bit30_watch.sv */
/*
  Watches bit 30 of a group of energy accumulators and pulses when
  any of them changes. Inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module mefe_bit30_watch #(
  parameter int unsigned N = 3
) (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [N-1:0] bit30_i,
  output logic              change_o
);
  import mefe_pkg::*;

  logic [N-1:0] prev_reg;
  logic         primed_reg;

  // First sample after reset only loads, so a nonzero start is no event
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      prev_reg   <= '0;
      primed_reg <= 1'b0;
    end
    else
    begin
      prev_reg   <= bit30_i;
      primed_reg <= 1'b1;
    end
  end

  // Any flipped bit is one change event
  assign change_o = primed_reg & (|(prev_reg ^ bit30_i));

endmodule

/* File: rtl/mefe_seq_check.sv */
/*
  Phase order checker: after a rising zero crossing on phase A the next
  rising crossing must be on phase B; phase C first is an error.
  Crossing pulses are one cycle long, on the same clock.
*/
`timescale 1ns/1ps
module mefe_seq_check (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic zx_a_i,
  input  wire logic zx_b_i,
  input  wire logic zx_c_i,
  output logic      order_err_o
);
  import mefe_pkg::*;

  mefe_seq_state_t state_reg;
  mefe_seq_state_t state_next;
  logic            err_next;

  // B beats C when both arrive together, so a tie is never an error
  always_comb
  begin
    state_next = state_reg;
    err_next   = 1'b0;
    case (state_reg)
      MEFE_WAIT_A:
        if (zx_a_i)
          state_next = MEFE_AFTER_A;
      MEFE_AFTER_A:
        if (zx_b_i)
          state_next = MEFE_WAIT_A;
        else if (zx_c_i)
        begin
          state_next = MEFE_WAIT_A;
          err_next   = 1'b1;
        end
      default:
        state_next = MEFE_WAIT_A;
    endcase
  end

  // Error is a one-cycle pulse
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg   <= MEFE_WAIT_A;
      order_err_o <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      order_err_o <= err_next;
    end
  end

endmodule

/* File: test/mefe_top_assertions.sv */
/*
  Port checker for mefe_top: status reads, peak capture, irq release.
  Assumes one clock and the synchronous active-high reset of the block.
*/
`timescale 1ns/1ps
module mefe_top_assertions (
  input wire logic                        core_clk_i,
  input wire logic                        sys_rst_i,
  input wire logic [mefe_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic                        reg_wr_i,
  input wire logic                        reg_rd_i,
  input wire logic [mefe_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                        high_voltage_i,
  input wire logic [2:0]                  high_voltage_phase_i,
  input wire logic                        zx_rise_a_i,
  input wire logic                        zx_rise_b_i,
  input wire logic                        zx_rise_c_i,
  input wire logic                        current_peak_end_i,
  input wire logic [31:0]                 current_peak_value_i,
  input wire logic                        voltage_peak_end_i,
  input wire logic                        irq_o
);
  import mefe_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Read strobes aimed at the status, phase and current peak registers
  wire rd_st = reg_rd_i && reg_addr_i == ADDR_EVENT_STATUS_FIRST;
  wire rd_ph = reg_rd_i && reg_addr_i == ADDR_PHASE_EVENT;
  wire rd_ip = reg_rd_i && reg_addr_i == ADDR_CURRENT_PEAK && !current_peak_end_i;

  a_rsvd_one_bit: assert property (rd_st |=> reg_rdata_o[BIT_RSVD_ONE])
    else $error("reserved one bit read low");
  a_rsvd_zero_bit: assert property (rd_st |=> !reg_rdata_o[BIT_RSVD_ZERO])
    else $error("reserved zero bit read high");
  a_upper_bits_zero: assert property (rd_st |=> reg_rdata_o[31:25] == 7'h00)
    else $error("status bits 31 to 25 not zero");
  a_high_volt_set: assert property (high_voltage_i ##1 !reg_wr_i ##1 rd_st |=> reg_rdata_o[BIT_HIGH_VOLTAGE])
    else $error("high voltage flag missing");
  a_high_volt_phase: assert property (high_voltage_i ##1 (!reg_wr_i)[*3] ##1 rd_ph |=>
    (reg_rdata_o[11:9] & $past(high_voltage_phase_i, 5)) == $past(high_voltage_phase_i, 5))
    else $error("high voltage phase field missing");
  a_order_err_set: assert property ((zx_rise_a_i && !zx_rise_b_i && !zx_rise_c_i) ##1
    (!zx_rise_b_i && !zx_rise_c_i)[*2] ##1 (zx_rise_c_i && !zx_rise_b_i)
    ##1 (!reg_wr_i)[*2] ##1 rd_st |=> reg_rdata_o[BIT_PHASE_ORDER])
    else $error("phase order flag missing");
  a_cur_peak_value: assert property (current_peak_end_i ##1 (!current_peak_end_i)[*3] ##1 rd_ip |=>
    reg_rdata_o == $past(current_peak_value_i, 5))
    else $error("current peak value not held");
  a_volt_peak_set: assert property (voltage_peak_end_i ##1 !reg_wr_i ##1 rd_st |=>
    reg_rdata_o[BIT_VOLTAGE_PEAK])
    else $error("voltage peak flag missing");
  a_irq_needs_write: assert property ($fell(irq_o) |-> $past(reg_wr_i) || $past(sys_rst_i))
    else $error("interrupt dropped without a write");

  // Main scenarios reached
  c_high_volt_irq: cover property (high_voltage_i ##1 irq_o);
  c_order_err: cover property (zx_rise_a_i ##3 zx_rise_c_i);
  c_irq_release: cover property ($fell(irq_o));
endmodule

bind mefe_top mefe_top_assertions i_mefe_top_assertions (.*);

/* File: test/mefe_top_tb.sv */
/*
  Self-checking bench for mefe_top: register port, events, masks, irq.
  Assumes the register port answers reads one cycle later, no waits.
*/
`timescale 1ns/1ps
module mefe_top_tb;
  import mefe_pkg::*;
  logic                    core_clk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic [ADDR_W-1:0]       reg_addr_i = 16'h0000;
  logic [DATA_W-1:0]       reg_wdata_i = 32'h0000_0000;
  logic                    reg_wr_i = 1'b0;
  logic                    reg_rd_i = 1'b0;
  logic [DATA_W-1:0]       reg_rdata_o;
  logic                    high_voltage_i = 1'b0;
  logic [2:0]              high_voltage_phase_i = 3'h0;
  logic                    zx_rise_a_i = 1'b0;
  logic                    zx_rise_b_i = 1'b0;
  logic                    zx_rise_c_i = 1'b0;
  logic                    sample_valid_i = 1'b0;
  logic signed [27:0]      computed_current_total_i = 28'h000_0000;
  logic signed [27:0]      neutral_current_sample_i = 28'h000_0000;
  logic                    current_peak_end_i = 1'b0;
  logic [31:0]             current_peak_value_i = 32'h0000_0000;
  logic                    voltage_peak_end_i = 1'b0;
  logic [31:0]             voltage_peak_value_i = 32'h0000_0000;
  logic [2:0]              eb [5];
  logic                    half_cycle_tick_i = 1'b0;
  logic                    irq_o;
  int                      mismatches = 0;
  int                      samples_checked = 0;

  mefe_top i_mefe_top (.*, .real_energy_b30_i(eb[0]), .fund_real_energy_b30_i(eb[1]),
    .quad_energy_b30_i(eb[2]), .fund_quad_energy_b30_i(eb[3]), .apparent_energy_b30_i(eb[4]));

  // 25 MHz core clock
  always #20 core_clk_i = ~core_clk_i;

  // Status value with the fixed reserved one included
  function automatic logic [31:0] st(input logic [31:0] ev);
    return ev | (32'h0000_0001 << BIT_RSVD_ONE);
  endfunction

  task cmp(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles: strobe for one cycle, read data sampled in the next
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task chk(input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 cmp(reg_rdata_o, e);
  endtask

  // Event pulses; the spare cycle covers the two-cycle flags
  task zx(input logic [2:0] p);
    @(posedge core_clk_i);
    {zx_rise_c_i, zx_rise_b_i, zx_rise_a_i} <= p;
    @(posedge core_clk_i);
    {zx_rise_c_i, zx_rise_b_i, zx_rise_a_i} <= 3'h0;
    @(posedge core_clk_i);
  endtask

  task smp(input logic [27:0] t, input logic [27:0] n);
    @(posedge core_clk_i);
    sample_valid_i <= 1'b1;
    computed_current_total_i <= t;
    neutral_current_sample_i <= n;
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task tick;
    @(posedge core_clk_i);
    half_cycle_tick_i <= 1'b1;
    @(posedge core_clk_i);
    half_cycle_tick_i <= 1'b0;
    #1;
  endtask

  task results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #(40 * 5000);
    mismatches++;
    results;
  end

  // Main sequence
  initial
  begin
    int k, n, ti;
    logic [31:0] v, w;
    for (k = 0; k < 5; k++)
      eb[k] = 3'h0;
    v = $urandom(32'hc9fe);
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, reserved bits, unmapped place
    chk(ADDR_EVENT_STATUS_FIRST, st(0));
    chk(ADDR_INTERRUPT_EN_FIRST, 32'h0000_0000);
    wr(ADDR_EVENT_STATUS_FIRST, 32'hFFFF_FFFF);
    chk(ADDR_EVENT_STATUS_FIRST, st(0));
    v = $urandom;
    wr(ADDR_INTERRUPT_EN_FIRST, v);
    chk(ADDR_INTERRUPT_EN_FIRST, v & 32'h0000_003F);
    wr(ADDR_INTERRUPT_EN_FIRST, 32'h0000_0000);
    chk(16'hE5FF, 32'h0000_0000);
    // High voltage: flag, phase field, mask, write-one clear
    v = $urandom_range(7, 1);
    @(posedge core_clk_i);
    high_voltage_i <= 1'b1;
    high_voltage_phase_i <= v[2:0];
    @(posedge core_clk_i);
    high_voltage_i <= 1'b0;
    high_voltage_phase_i <= 3'h0;
    chk(ADDR_EVENT_STATUS_FIRST, st(32'h1 << BIT_HIGH_VOLTAGE));
    chk(ADDR_PHASE_EVENT, v << HV_PHASE_LSB);
    cmp(irq_o, 1'b0);
    wr(ADDR_EVENT_ENABLE_UPPER, 32'h1 << BIT_HIGH_VOLTAGE);
    cmp(irq_o, 1'b1);
    wr(ADDR_EVENT_STATUS_FIRST, 32'h0000_0000);
    cmp(irq_o, 1'b1);
    wr(ADDR_EVENT_STATUS_FIRST, 32'h1 << BIT_HIGH_VOLTAGE);
    cmp(irq_o, 1'b0);
    chk(ADDR_PHASE_EVENT, 32'h0000_0000);
    wr(ADDR_EVENT_ENABLE_UPPER, 32'h0000_0000);
    // Phase order: A-B-C and A then B with C are fine, A then C is not
    zx(3'h1);
    zx(3'h2);
    zx(3'h4);
    zx(3'h1);
    zx(3'h6);
    chk(ADDR_EVENT_STATUS_FIRST, st(0));
    zx(3'h1);
    zx(3'h4);
    chk(ADDR_EVENT_STATUS_FIRST, st(32'h1 << BIT_PHASE_ORDER));
    wr(ADDR_EVENT_STATUS_FIRST, 32'h1 << BIT_PHASE_ORDER);
    // Sum disagreement at the threshold and one above it
    ti = $urandom_range(20'hF_FFFF);
    k = $urandom_range(1000, 1);
    wr(ADDR_SUM_DISAGREE_THRESH, ti);
    chk(ADDR_SUM_DISAGREE_THRESH, ti);
    smp(28'(-(ti + k)), 28'(k));
    smp(28'(k), 28'(-(k + ti)));
    chk(ADDR_EVENT_STATUS_FIRST, st(0));
    smp(28'(k), 28'(-(k + ti + 1)));
    chk(ADDR_EVENT_STATUS_FIRST, st(32'h1 << BIT_SUM_DISAGREE));
    wr(ADDR_EVENT_STATUS_FIRST, 32'h1 << BIT_SUM_DISAGREE);
    wr(ADDR_EVENT_ENABLE_UPPER, 32'hFFFF_FFFF);
    chk(ADDR_EVENT_ENABLE_UPPER, 32'h019C_0000);
    // Both peak periods end together; values captured on that cycle
    v = $urandom;
    w = $urandom;
    @(posedge core_clk_i);
    current_peak_end_i <= 1'b1;
    voltage_peak_end_i <= 1'b1;
    current_peak_value_i <= v;
    voltage_peak_value_i <= w;
    @(posedge core_clk_i);
    current_peak_end_i <= 1'b0;
    voltage_peak_end_i <= 1'b0;
    current_peak_value_i <= ~v;
    voltage_peak_value_i <= ~w;
    chk(ADDR_EVENT_STATUS_FIRST, st(32'h3 << BIT_CURRENT_PEAK));
    cmp(irq_o, 1'b1);
    chk(ADDR_CURRENT_PEAK, v);
    chk(ADDR_VOLTAGE_PEAK, w);
    wr(ADDR_EVENT_STATUS_FIRST, 32'h3 << BIT_CURRENT_PEAK);
    cmp(irq_o, 1'b0);
    // Bit 30 change per energy kind: flag while masked, irq once enabled
    for (k = 0; k < ENERGY_KINDS; k++)
    begin
      n = $urandom_range(2, 0);
      @(posedge core_clk_i);
      eb[k][n] <= ~eb[k][n];
      @(posedge core_clk_i);
      #1 cmp(irq_o, 1'b0);
      chk(ADDR_ENERGY_STATUS, 32'h1 << k);
      wr(ADDR_INTERRUPT_EN_FIRST, 32'h1 << k);
      cmp(irq_o, 1'b1);
      wr(ADDR_ENERGY_STATUS, 32'h1 << k);
      cmp(irq_o, 1'b0);
    end
    // Line-cycle done after exactly the programmed half cycles
    n = $urandom_range(5, 2);
    wr(ADDR_HALF_CYCLE_COUNT, n);
    wr(ADDR_LINE_CONTROL, 32'h1 << BIT_LINE_MODE);
    wr(ADDR_INTERRUPT_EN_FIRST, 32'h1 << BIT_LINE_CYCLE_DONE);
    repeat (n - 1) tick;
    cmp(irq_o, 1'b0);
    tick;
    cmp(irq_o, 1'b1);
    chk(ADDR_ENERGY_STATUS, 32'h1 << BIT_LINE_CYCLE_DONE);
    wr(ADDR_ENERGY_STATUS, 32'h1 << BIT_LINE_CYCLE_DONE);
    cmp(irq_o, 1'b0);
    results;
  end
endmodule
